// >>> hw/cip_defs.vh
// Constants for the charger input protection sequencer.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef CIP_DEFS_VH
`define CIP_DEFS_VH

// ---------------------------------------------------------------
// Clock and default timer durations (microseconds, then cycles)
// ---------------------------------------------------------------
`define CIP_CLK_MHZ        16'h000A
`define CIP_PG_DGL_US      16'h000A
`define CIP_OV_BLANK_US    16'h0001
`define CIP_OV_RESTART_US  16'h001E
`define CIP_OI_BLANK_US    16'h0005
`define CIP_OI_RECOV_US    16'h0064
`define CIP_RAMP_US        16'h0002
`define CIP_PG_DGL_CYC     (`CIP_PG_DGL_US * `CIP_CLK_MHZ)
`define CIP_OV_BLANK_CYC   (`CIP_OV_BLANK_US * `CIP_CLK_MHZ)
`define CIP_OV_RESTART_CYC (`CIP_OV_RESTART_US * `CIP_CLK_MHZ)
`define CIP_OI_BLANK_CYC   (`CIP_OI_BLANK_US * `CIP_CLK_MHZ)
`define CIP_OI_RECOV_CYC   (`CIP_OI_RECOV_US * `CIP_CLK_MHZ)
`define CIP_RAMP_CYC       (`CIP_RAMP_US * `CIP_CLK_MHZ)

// ---------------------------------------------------------------
// Fault counters and timer limits
// ---------------------------------------------------------------
`define CIP_LOCK_COUNT     4'hF
`define CIP_CNT_ZERO       4'h0
`define CIP_CNT_ONE        4'h1
`define CIP_TMR_ZERO       16'h0000
`define CIP_TMR_ONE        16'h0001
`define CIP_TMR_MAX        16'hFFFF

// ---------------------------------------------------------------
// Synchroniser bit positions
// ---------------------------------------------------------------
`define CIP_NSYNC          6
`define CIP_SI_SUPPLY      0
`define CIP_SI_INOV        1
`define CIP_SI_IOV         2
`define CIP_SI_BATOV       3
`define CIP_SI_THERM       4
`define CIP_SI_ENN         5

// ---------------------------------------------------------------
// Register map (byte addresses) and fields
// ---------------------------------------------------------------
`define CIP_ADDR_CTRL      12'h000
`define CIP_ADDR_STATUS    12'h004
`define CIP_ADDR_COUNTS    12'h008
`define CIP_CTRL_SOFTOFF   0
`define CIP_ZERO32         32'h0000_0000

`endif

// >>> hw/cip_seq.v
// Charger input protection sequencer: pass switch control, timers,
// fault counters, open-drain fault flag and a small APB register file.
// Assumes analog comparators give digital levels and the pin pad
// resolves the fault flag from its output enable.
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "cip_defs.vh"

// Behaviour
// [RL1] Below supply lockout: powered down, switch off, fault flag released.
// [RL2] Supply rising past lockout clears all counters and sequencing state.
// [RL3] After reset wait power-good deglitch, then soft-start only if all safe.
// [RL4] Input overvoltage at deglitch end: never switch on, protect, flag fault.
// [RL5] Input overvoltage clamps output and blanks; short spikes resume normally.
// [RL6] Overvoltage longer than blanking time turns the switch off.
// [RL7] After overvoltage off, once safe wait restart delay, then soft-start.
// [RL8] Overcurrent limits current and blanks; short overcurrent resumes.
// [RL9] Full-blank overcurrent: off with fault for recovery time, then retry.
// [RL10] Each overcurrent off counts; fifteenth latches switch off.
// [RL11] Supply cycle or enable off-then-on clears both fault counters.
// [RL12] Overcurrent turn-off uses the soft-stop ramp.
// [RL13] Battery overvoltage turns switch off and flags fault.
// [RL14] Switch returns once battery falls below threshold minus hysteresis.
// [RL15] Battery faults counted separately; fifteenth latches switch off.
// [RL16] Battery overvoltage turn-off uses the soft-stop ramp.
// [RL17] Thermal trip turns off and flags; back on after thermal release.
// [RL18] Enable high forces switch off; low allows on when all safe.
// [RL19] Enable defaults to enabled when undriven.
// [RL20] While disabled the fault flag stays released.
// [RL21] Enabled: fault flag low during fault events, released when safe.
// [RL22] Timer durations are parameters counted in clock cycles.
// [RL23] Comparators and enable synchronised; fault flag as low-driving enable.
module cip_seq #(
	parameter [15:0] PG_DGL_CYC     = `CIP_PG_DGL_CYC,
	parameter [15:0] OV_BLANK_CYC   = `CIP_OV_BLANK_CYC,
	parameter [15:0] OV_RESTART_CYC = `CIP_OV_RESTART_CYC,
	parameter [15:0] OI_BLANK_CYC   = `CIP_OI_BLANK_CYC,
	parameter [15:0] OI_RECOV_CYC   = `CIP_OI_RECOV_CYC,
	parameter [15:0] RAMP_CYC       = `CIP_RAMP_CYC
)(
	input  wire        REF_CLK,
	input  wire        RST,
	input  wire        SUPPLY_OK,
	input  wire        INPUT_OVER,
	input  wire        CURRENT_OVER,
	input  wire        BATTERY_OVER,
	input  wire        THERMAL_TRIP,
	input  wire        ENABLE_N,
	output reg         PASS_SWITCH_ON,
	output reg         SOFT_START,
	output reg         SOFT_STOP,
	output reg         OUTPUT_CLAMP,
	output reg         CURRENT_LIMIT,
	output wire        FAULT_N_O,
	output reg         FAULT_N_OE,
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [11:0] PADDR,
	input  wire [31:0] PWDATA,
	output reg  [31:0] PRDATA,
	output wire        PREADY,
	output wire        PSLVERR
);

	// ---------------------------------------------------------------
	// States
	// ---------------------------------------------------------------
	localparam [3:0] ST_PDOWN   = 4'h0;
	localparam [3:0] ST_PGDGL   = 4'h1;
	localparam [3:0] ST_SSTART  = 4'h2;
	localparam [3:0] ST_ON      = 4'h3;
	localparam [3:0] ST_OVBLANK = 4'h4;
	localparam [3:0] ST_OIBLANK = 4'h5;
	localparam [3:0] ST_SSTOP   = 4'h6;
	localparam [3:0] ST_OFF     = 4'h7;
	localparam [3:0] ST_OVREST  = 4'h8;
	localparam [3:0] ST_OIREC   = 4'h9;
	localparam [3:0] ST_LOCK    = 4'hA;
	localparam [3:0] ST_DIS     = 4'hB;
	localparam [1:0] CA_OV   = 2'h0;
	localparam [1:0] CA_OI   = 2'h1;
	localparam [1:0] CA_BAT  = 2'h2;
	localparam [1:0] CA_TH   = 2'h3;
	reg  [`CIP_NSYNC-1:0] s1_r;
	reg  [`CIP_NSYNC-1:0] s2_r;
	reg  [`CIP_NSYNC-1:0] s3_r;
	reg  [`CIP_NSYNC-1:0] filt_r;
	wire [`CIP_NSYNC-1:0] raw_in;
	reg  [3:0]            state_r;
	reg  [3:0]            state_nxt;
	reg  [1:0]            cause_r;
	reg  [1:0]            cause_nxt;
	reg  [15:0]           timer_r;
	reg  [3:0]            oi_cnt_r;
	reg  [3:0]            oi_cnt_nxt;
	reg  [3:0]            bat_cnt_r;
	reg  [3:0]            bat_cnt_nxt;
	reg                   lock_pend_r;
	reg                   lock_pend_nxt;
	reg                   en_prev_r;
	reg                   soft_off_r;
	wire                  supply_ok;
	wire                  in_over;
	wire                  i_over;
	wire                  bat_over;
	wire                  therm;
	wire                  enabled;
	wire                  reenable;
	wire                  wr_en;
	wire                  addr_ok;
	// Pin inputs, active-low enable inverted by nothing; default low = enabled
	assign raw_in = {ENABLE_N, THERMAL_TRIP, BATTERY_OVER, CURRENT_OVER,
		INPUT_OVER, SUPPLY_OK};

	// ---------------------------------------------------------------
	// Synchronisers
	// ---------------------------------------------------------------
	// Three stages; a change is taken only when stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < `CIP_NSYNC; gi = gi + 1)
		begin : g_sync
			always @(posedge REF_CLK)
			begin
				if (RST)
				begin
					s1_r[gi]   <= 1'b0;
					s2_r[gi]   <= 1'b0;
					s3_r[gi]   <= 1'b0;
					filt_r[gi] <= 1'b0;
				end
				else
				begin
					s1_r[gi] <= raw_in[gi];
					s2_r[gi] <= s1_r[gi];
					s3_r[gi] <= s2_r[gi];
					if (s2_r[gi] == s3_r[gi])
						filt_r[gi] <= s3_r[gi]; // [RL23]
				end
			end
		end
	endgenerate
	assign supply_ok = filt_r[`CIP_SI_SUPPLY];
	assign in_over   = filt_r[`CIP_SI_INOV];
	assign i_over    = filt_r[`CIP_SI_IOV];
	assign bat_over  = filt_r[`CIP_SI_BATOV];
	assign therm     = filt_r[`CIP_SI_THERM];
	// Undriven pin reads low through the pad pull-down, so reset value enables
	assign enabled   = ~filt_r[`CIP_SI_ENN] & ~soft_off_r; // [RL19] [RL18]
	assign reenable  = enabled & ~en_prev_r; // [RL11]

	// ---------------------------------------------------------------
	// Sequencer next state
	// ---------------------------------------------------------------
	// Faults in the running states: thermal, battery, input, then current
	always @*
	begin
		state_nxt     = state_r;
		cause_nxt     = cause_r;
		oi_cnt_nxt    = oi_cnt_r;
		bat_cnt_nxt   = bat_cnt_r;
		lock_pend_nxt = lock_pend_r;
		if (reenable)
		begin
			oi_cnt_nxt  = `CIP_CNT_ZERO; // [RL11]
			bat_cnt_nxt = `CIP_CNT_ZERO; // [RL11]
		end
		case (state_r)
			ST_PDOWN:
			begin
				oi_cnt_nxt    = `CIP_CNT_ZERO; // [RL2]
				bat_cnt_nxt   = `CIP_CNT_ZERO; // [RL2]
				lock_pend_nxt = 1'b0;
				if (supply_ok)
					state_nxt = ST_PGDGL; // [RL2]
			end
			ST_PGDGL:
			begin
				if (timer_r >= PG_DGL_CYC) // [RL3] [RL22]
				begin
					if (in_over)
					begin
						state_nxt = ST_OFF; // [RL4]
						cause_nxt = CA_OV;
					end
					else if (therm)
					begin
						state_nxt = ST_OFF;
						cause_nxt = CA_TH;
					end
					else if (bat_over)
					begin
						state_nxt = ST_OFF;
						cause_nxt = CA_BAT;
					end
					else
						state_nxt = ST_SSTART; // [RL3]
				end
			end
			ST_SSTART, ST_ON:
			begin
				if (therm)
				begin
					state_nxt = ST_OFF; // [RL17]
					cause_nxt = CA_TH;
				end
				else if (bat_over)
				begin
					state_nxt   = ST_SSTOP; // [RL13] [RL16]
					cause_nxt   = CA_BAT;
					bat_cnt_nxt = bat_cnt_r + `CIP_CNT_ONE; // [RL15]
					if (bat_cnt_r == `CIP_LOCK_COUNT - `CIP_CNT_ONE)
						lock_pend_nxt = 1'b1; // [RL15]
				end
				else if (in_over)
					state_nxt = ST_OVBLANK; // [RL5]
				else if (i_over)
					state_nxt = ST_OIBLANK; // [RL8]
				else if (state_r == ST_SSTART && timer_r >= RAMP_CYC)
					state_nxt = ST_ON;
			end
			ST_OVBLANK:
			begin
				if (!in_over)
					state_nxt = ST_ON; // [RL5]
				else if (timer_r >= OV_BLANK_CYC)
				begin
					state_nxt = ST_OFF; // [RL6]
					cause_nxt = CA_OV;
				end
			end
			ST_OIBLANK:
			begin
				if (!i_over)
					state_nxt = ST_ON; // [RL8]
				else if (timer_r >= OI_BLANK_CYC)
				begin
					state_nxt  = ST_SSTOP; // [RL9] [RL12]
					cause_nxt  = CA_OI;
					oi_cnt_nxt = oi_cnt_r + `CIP_CNT_ONE; // [RL10]
					if (oi_cnt_r == `CIP_LOCK_COUNT - `CIP_CNT_ONE)
						lock_pend_nxt = 1'b1; // [RL10]
				end
			end
			ST_SSTOP:
			begin
				if (timer_r >= RAMP_CYC)
				begin
					if (lock_pend_r)
						state_nxt = ST_LOCK; // [RL10] [RL15]
					else if (cause_r == CA_OI)
						state_nxt = ST_OIREC; // [RL9]
					else
						state_nxt = ST_OFF;
				end
			end
			ST_OFF:
			begin
				case (cause_r)
					CA_OV:
						if (!in_over)
							state_nxt = ST_OVREST; // [RL7]
					CA_BAT:
						if (!bat_over)
							state_nxt = ST_SSTART; // [RL14]
					CA_TH:
						if (!therm)
							state_nxt = ST_SSTART; // [RL17]
					default:
						state_nxt = ST_SSTART;
				endcase
			end
			ST_OVREST:
			begin
				if (in_over)
					state_nxt = ST_OFF;
				else if (timer_r >= OV_RESTART_CYC)
					state_nxt = ST_SSTART; // [RL7]
			end
			ST_OIREC:
			begin
				if (timer_r >= OI_RECOV_CYC)
					state_nxt = ST_SSTART; // [RL9]
			end
			ST_LOCK:
				state_nxt = ST_LOCK; // Left only via the enable toggle or supply loss [RL11]
			ST_DIS:
			begin
				if (enabled)
				begin
					state_nxt     = ST_PGDGL;
					lock_pend_nxt = 1'b0;
				end
			end
			default:
				state_nxt = ST_PDOWN;
		endcase
		// Disable overrides every state but power-down
		if (!enabled && state_r != ST_PDOWN)
			state_nxt = ST_DIS; // [RL18]
		// Supply loss wins over everything
		if (!supply_ok)
			state_nxt = ST_PDOWN; // [RL1]
	end

	// ---------------------------------------------------------------
	// Sequencer registers and registered pin outputs
	// ---------------------------------------------------------------
	// Outputs decode the next state so they come straight from flops
	always @(posedge REF_CLK)
	begin
		if (RST)
		begin
			state_r        <= ST_PDOWN;
			cause_r        <= CA_OV;
			timer_r        <= `CIP_TMR_ZERO;
			oi_cnt_r       <= `CIP_CNT_ZERO;
			bat_cnt_r      <= `CIP_CNT_ZERO;
			lock_pend_r    <= 1'b0;
			en_prev_r      <= 1'b1; // Matches enabled, so no false re-enable
			PASS_SWITCH_ON <= 1'b0;
			SOFT_START     <= 1'b0;
			SOFT_STOP      <= 1'b0;
			OUTPUT_CLAMP   <= 1'b0;
			CURRENT_LIMIT  <= 1'b0;
			FAULT_N_OE     <= 1'b1;
		end
		else
		begin
			state_r     <= state_nxt;
			cause_r     <= cause_nxt;
			oi_cnt_r    <= oi_cnt_nxt;
			bat_cnt_r   <= bat_cnt_nxt;
			lock_pend_r <= lock_pend_nxt;
			en_prev_r   <= enabled;
			// Timer restarts on every state change
			if (state_nxt != state_r)
				timer_r <= `CIP_TMR_ZERO;
			else if (timer_r != `CIP_TMR_MAX)
				timer_r <= timer_r + `CIP_TMR_ONE;
			PASS_SWITCH_ON <= (state_nxt == ST_SSTART) || (state_nxt == ST_ON) ||
				(state_nxt == ST_OVBLANK) || (state_nxt == ST_OIBLANK) ||
				(state_nxt == ST_SSTOP);
			SOFT_START    <= (state_nxt == ST_SSTART); // [RL3] [RL7]
			SOFT_STOP     <= (state_nxt == ST_SSTOP); // [RL12] [RL16]
			OUTPUT_CLAMP  <= (state_nxt == ST_OVBLANK); // [RL5]
			CURRENT_LIMIT <= (state_nxt == ST_OIBLANK); // [RL8]
			// Pull low only while enabled and the switch is soft-stopping or held off by a fault
			FAULT_N_OE <= ~(supply_ok && enabled && ((state_nxt == ST_OFF) ||
				(state_nxt == ST_SSTOP) || (state_nxt == ST_OIREC) ||
				(state_nxt == ST_LOCK))); // [RL20] [RL21] [RL1] [RL9]
		end
	end

	// Open drain: the pad only ever pulls low
	assign FAULT_N_O = 1'b0; // [RL23]

	// ---------------------------------------------------------------
	// APB register file
	// ---------------------------------------------------------------
	// Zero wait states; read data captured in the setup cycle
	assign PREADY  = 1'b1;
	assign addr_ok = (PADDR == `CIP_ADDR_CTRL) || (PADDR == `CIP_ADDR_STATUS) ||
		(PADDR == `CIP_ADDR_COUNTS);
	assign PSLVERR = PSEL & PENABLE & ~addr_ok;
	assign wr_en   = PSEL & PENABLE & PWRITE & (PADDR == `CIP_ADDR_CTRL);

	always @(posedge REF_CLK)
	begin
		if (RST)
		begin
			soft_off_r <= 1'b0;
			PRDATA     <= `CIP_ZERO32;
		end
		else
		begin
			if (wr_en)
				soft_off_r <= PWDATA[`CIP_CTRL_SOFTOFF];
			if (PSEL && !PENABLE && !PWRITE)
			begin
				case (PADDR)
					`CIP_ADDR_CTRL:
						PRDATA <= {31'h0000_0000, soft_off_r};
					`CIP_ADDR_STATUS:
						PRDATA <= {21'h00_0000, ~FAULT_N_OE, lock_pend_r, enabled,
							supply_ok, PASS_SWITCH_ON, cause_r, state_r};
					`CIP_ADDR_COUNTS:
						PRDATA <= {20'h0_0000, bat_cnt_r, 4'h0, oi_cnt_r};
					default:
						PRDATA <= `CIP_ZERO32;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// >>> verification/cip_seq_monitor.sv
// Assertion checker for the protection sequencer port behaviour.
// Assumes a bind onto cip_seq that hands on the timer parameters.
`timescale 1ns/1ns
`default_nettype none
module cip_seq_monitor #(
	parameter [15:0] OV_BLANK_CYC = 16'h0008,
	parameter [15:0] OI_BLANK_CYC = 16'h0006,
	parameter [15:0] RAMP_CYC     = 16'h0004
)(
	input wire logic        REF_CLK,
	input wire logic        RST,
	input wire logic        SUPPLY_OK,
	input wire logic        ENABLE_N,
	input wire logic        PASS_SWITCH_ON,
	input wire logic        SOFT_STOP,
	input wire logic        OUTPUT_CLAMP,
	input wire logic        CURRENT_LIMIT,
	input wire logic        FAULT_N_OE,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic [11:0] PADDR,
	input wire logic        PSLVERR,
	input wire logic        PREADY
);
	// ----------------------------------------
	// Timing limits and properties
	// ----------------------------------------
	localparam int OVB_LIM = OV_BLANK_CYC + 1;
	localparam int OIB_LIM = OI_BLANK_CYC + 1;
	localparam int RMP_LIM = RAMP_CYC + 1;
	// Eight low samples cover the five-edge input filter with margin
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);
	a_pdown_off: assert property (!SUPPLY_OK [*8] |-> !PASS_SWITCH_ON && FAULT_N_OE)
		else $error("switch or flag active in power down");
	a_dis_release: assert property (ENABLE_N [*8] |-> FAULT_N_OE)
		else $error("fault flag driven while disabled");
	a_clamp_len: assert property ($rose(OUTPUT_CLAMP) |-> ##[1:OVB_LIM] !OUTPUT_CLAMP)
		else $error("clamp outlasts blanking");
	a_limit_len: assert property ($rose(CURRENT_LIMIT) |-> ##[1:OIB_LIM] !CURRENT_LIMIT)
		else $error("current limit outlasts blanking");
	a_stop_len: assert property ($rose(SOFT_STOP) |-> ##[1:RMP_LIM] !SOFT_STOP)
		else $error("soft stop too long");
	a_stop_fault: assert property (SOFT_STOP |-> PASS_SWITCH_ON && !FAULT_N_OE)
		else $error("soft stop without switch or flag");
	a_blank_quiet: assert property (OUTPUT_CLAMP || CURRENT_LIMIT |-> PASS_SWITCH_ON && FAULT_N_OE)
		else $error("blanking dropped switch or drove flag");
	a_apb_error: assert property (PSEL && PENABLE |-> PREADY && (PSLVERR !=
		(PADDR == 12'h000 || PADDR == 12'h004 || PADDR == 12'h008)))
		else $error("bus error response wrong");
endmodule
`default_nettype wire

// >>> verification/cip_host.sv
// Host processor model: GPIO enable output and pulled-up fault input.
// Assumes the bench requests disable on dis_req; enable idles low.
`timescale 1ns/1ns
`default_nettype none
module cip_host (
	input  wire logic clk,
	input  wire logic dis_req,
	input  wire logic fault_n_o,
	input  wire logic fault_n_oe,
	output wire logic enable_n,
	output wire logic fault_n
);
	// ----------------------------------------
	// GPIO and pull-up
	// ----------------------------------------
	// Starts low like the pad pull-down, so the device is enabled
	logic dis_r = 1'b0;
	// GPIO changes just after the edge; toggling clears counters
	always @(posedge clk)
		dis_r <= dis_req;
	assign enable_n = dis_r;
	// Released line reads high through the external pull-up
	assign fault_n = fault_n_oe ? 1'b1 : fault_n_o;
endmodule
`default_nettype wire

// >>> verification/charger_input_protection_fsm_tb.sv
// Self-checking bench for cip_seq with a host model and bound checker.
// Assumes short timer parameters; register reads go over APB.
`timescale 1ns/1ns
`default_nettype none
module charger_input_protection_fsm_tb;
	localparam [15:0] PG = 16'h0008, OVB = 16'h0008, OVR = 16'h000A;
	localparam [15:0] OIB = 16'h0006, OIR = 16'h000A, RMP = 16'h0004;
	localparam int    I_ON = 0, I_SS = 1, I_STOP = 2, I_CLP = 3, I_LIM = 4, I_FLT = 5;
	logic        clk, rst = 1'b1, supply = 1'b0, in_ov = 1'b0, cur_ov = 1'b0;
	logic        bat_ov = 1'b0, therm = 1'b0, dis = 1'b0, psel = 1'b0, pen = 1'b0;
	logic        pwr = 1'b0, en_n, flt_n, fo, foe, rdy, err_s, sw, ss, stp, clp, lim, e;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	int          errors = 0, checked = 0, n, i;
	wire  [5:0]  obs = {flt_n, lim, clp, stp, ss, sw};
	// Clock at 100 ns period
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	cip_seq #(.PG_DGL_CYC(PG), .OV_BLANK_CYC(OVB), .OV_RESTART_CYC(OVR),
		.OI_BLANK_CYC(OIB), .OI_RECOV_CYC(OIR), .RAMP_CYC(RMP)) dut (
		.REF_CLK(clk), .RST(rst), .SUPPLY_OK(supply), .INPUT_OVER(in_ov),
		.CURRENT_OVER(cur_ov), .BATTERY_OVER(bat_ov), .THERMAL_TRIP(therm),
		.ENABLE_N(en_n), .PASS_SWITCH_ON(sw), .SOFT_START(ss), .SOFT_STOP(stp),
		.OUTPUT_CLAMP(clp), .CURRENT_LIMIT(lim), .FAULT_N_O(fo), .FAULT_N_OE(foe),
		.PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(rdy), .PSLVERR(err_s));
	cip_host u_host (.clk(clk), .dis_req(dis), .fault_n_o(fo), .fault_n_oe(foe),
		.enable_n(en_n), .fault_n(flt_n));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Counts negedge samples while a watched bit holds its value
	task run_len(input int idx, input logic v, input int mx);
		n = 0;
		while (obs[idx] === v && n < mx)
		begin
			n++;
			@(negedge clk);
		end
	endtask
	task wait_bit(input int idx, input logic v, input int mx);
		run_len(idx, ~v, mx);
		chk("wait", obs[idx], v);
	endtask
	// One APB transfer; request held until pready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (rdy !== 1'b1 && n < 20);
		rd = prdata;
		e = err_s;
		chk("pready", rdy, 1'b1);
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task stop_test;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task s_power_up;
		repeat (20) @(negedge clk);
		chk("off", sw, 1'b0);
		chk("flt", flt_n, 1'b1);
		@(posedge clk);
		supply <= 1'b1;
		run_len(I_ON, 1'b0, 200);
		chk("dgl", n > PG, 1'b1);
		chk("ss", ss, 1'b1);
		run_len(I_SS, 1'b1, 50);
		chk("ramp", n, RMP + 1);
	endtask
	task s_ov;
		@(posedge clk);
		in_ov <= 1'b1;
		repeat (4) @(posedge clk);
		in_ov <= 1'b0;
		wait_bit(I_CLP, 1'b1, 20);
		run_len(I_CLP, 1'b1, 50);
		chk("spike_on", sw, 1'b1);
		@(posedge clk);
		in_ov <= 1'b1;
		wait_bit(I_CLP, 1'b1, 20);
		run_len(I_CLP, 1'b1, 50);
		chk("blank", n, OVB + 1);
		chk("off", sw | stp, 1'b0);
		chk("flt", flt_n, 1'b0);
		@(posedge clk);
		in_ov <= 1'b0;
		wait_bit(I_FLT, 1'b1, 20);
		run_len(I_ON, 1'b0, 100);
		chk("restart", n, OVR + 1);
		chk("ss", ss, 1'b1);
		wait_bit(I_SS, 1'b0, 20);
	endtask
	task s_oc;
		@(posedge clk);
		cur_ov <= 1'b1;
		repeat (4) @(posedge clk);
		cur_ov <= 1'b0;
		wait_bit(I_LIM, 1'b1, 20);
		run_len(I_LIM, 1'b1, 50);
		chk("cont", {sw, stp}, 2'b10);
		@(posedge clk);
		cur_ov <= 1'b1;
		wait_bit(I_LIM, 1'b1, 20);
		run_len(I_LIM, 1'b1, 50);
		chk("blank", n, OIB + 1);
		chk("flt", flt_n, 1'b0);
		run_len(I_STOP, 1'b1, 50);
		chk("stop", n, RMP + 1);
		run_len(I_ON, 1'b0, 100);
		chk("recov", n, OIR + 1);
		chk("retry", ss, 1'b1);
		@(posedge clk);
		cur_ov <= 1'b0;
		wait_bit(I_SS, 1'b0, 20);
		wait_bit(I_FLT, 1'b1, 40);
	endtask
	// Overvoltage present when the deglitch ends
	task s_supply;
		@(posedge clk);
		supply <= 1'b0;
		in_ov <= 1'b1;
		wait_bit(I_ON, 1'b0, 20);
		repeat (10) @(negedge clk);
		chk("pd_flt", flt_n, 1'b1);
		@(posedge clk);
		supply <= 1'b1;
		run_len(I_ON, 1'b0, 40);
		chk("no_on", n, 40);
		chk("flt", flt_n, 1'b0);
		apb(1'b0, 12'h008, 32'h0000_0000);
		chk("cnt", rd, 32'h0000_0000);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk("stat", rd, 32'h0000_0587);
		@(posedge clk);
		in_ov <= 1'b0;
		wait_bit(I_ON, 1'b1, 100);
		wait_bit(I_SS, 1'b0, 20);
	endtask
	task s_oc_lock;
		@(posedge clk);
		cur_ov <= 1'b1;
		for (i = 0; i < 15; i++)
		begin
			wait_bit(I_STOP, 1'b1, 100);
			wait_bit(I_ON, 1'b0, 20);
		end
		@(posedge clk);
		cur_ov <= 1'b0;
		run_len(I_ON, 1'b0, 40);
		chk("latch", n, 40);
		apb(1'b0, 12'h008, 32'h0000_0000);
		chk("cnt", rd[3:0], 4'hF);
		@(posedge clk);
		dis <= 1'b1;
		repeat (12) @(negedge clk);
		chk("dis", {sw, flt_n}, 2'b01);
		@(posedge clk);
		dis <= 1'b0;
		wait_bit(I_ON, 1'b1, 100);
		apb(1'b0, 12'h008, 32'h0000_0000);
		chk("clr", rd[3:0], 4'h0);
		wait_bit(I_SS, 1'b0, 20);
	endtask
	task s_bat;
		for (i = 0; i < 15; i++)
		begin
			@(posedge clk);
			bat_ov <= 1'b1;
			wait_bit(I_STOP, 1'b1, 30);
			wait_bit(I_ON, 1'b0, 20);
			chk("flt", flt_n, 1'b0);
			@(posedge clk);
			bat_ov <= 1'b0;
			if (i < 14)
			begin
				wait_bit(I_ON, 1'b1, 100);
				wait_bit(I_SS, 1'b0, 20);
			end
		end
		run_len(I_ON, 1'b0, 40);
		chk("latch", n, 40);
		apb(1'b0, 12'h008, 32'h0000_0000);
		chk("bcnt", rd[11:8], 4'hF);
	endtask
	// Register soft-off clears the battery lockout; bus errors and read-only
	task s_regs;
		apb(1'b1, 12'h000, 32'h0000_0001);
		apb(1'b0, 12'h000, 32'h0000_0000);
		chk("ctrl", rd, 32'h0000_0001);
		chk("ctrl_err", e, 1'b0);
		repeat (12) @(negedge clk);
		chk("soft_off", {sw, flt_n}, 2'b01);
		apb(1'b1, 12'h000, 32'h0000_0000);
		wait_bit(I_ON, 1'b1, 100);
		apb(1'b1, 12'h008, 32'hFFFF_FFFF);
		apb(1'b0, 12'h008, 32'h0000_0000);
		chk("ro_cnt", rd, 32'h0000_0000);
		apb(1'b0, 12'h00C, 32'h0000_0000);
		chk("unmap", rd, 32'h0000_0000);
		chk("unmap_err", e, 1'b1);
		wait_bit(I_SS, 1'b0, 20);
	endtask
	task s_therm;
		@(posedge clk);
		therm <= 1'b1;
		wait_bit(I_ON, 1'b0, 20);
		chk("flt", flt_n, 1'b0);
		@(posedge clk);
		therm <= 1'b0;
		wait_bit(I_ON, 1'b1, 100);
		wait_bit(I_SS, 1'b0, 20);
		chk("rel", flt_n, 1'b1);
	endtask
	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		s_power_up;
		s_ov;
		s_oc;
		s_supply;
		s_oc_lock;
		s_bat;
		s_regs;
		s_therm;
		stop_test;
	end
	// Watchdog more than ten times the roughly twelve hundred cycles the run needs
	initial
	begin
		repeat (20000) @(posedge clk);
		errors++;
		stop_test;
	end
endmodule
bind cip_seq cip_seq_monitor #(.OV_BLANK_CYC(OV_BLANK_CYC), .OI_BLANK_CYC(OI_BLANK_CYC),
	.RAMP_CYC(RAMP_CYC)) u_mon (.REF_CLK(REF_CLK), .RST(RST), .SUPPLY_OK(SUPPLY_OK),
	.ENABLE_N(ENABLE_N), .PASS_SWITCH_ON(PASS_SWITCH_ON), .SOFT_STOP(SOFT_STOP),
	.OUTPUT_CLAMP(OUTPUT_CLAMP), .CURRENT_LIMIT(CURRENT_LIMIT), .FAULT_N_OE(FAULT_N_OE),
	.PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PSLVERR(PSLVERR), .PREADY(PREADY));
`default_nettype wire
